// [host_glue_defs.svh]
`ifndef HOST_GLUE_DEFS_SVH
`define HOST_GLUE_DEFS_SVH

// processor address decode
`define IO_SPACE_BIT 15
`define SEL_HIGH_LO 11
`define SEL_HIGH_HI 13
`define SEL_LOW_LO 14
`define SEL_LOW_HI 15
`define SWITCH_OR_CHIP_SELECT_BIT 3
`define REG_SEL_HI 2
`define REG_SEL_LO 0
// fixed upper nibble of the bus address byte
`define ADDR_FIXED_NIBBLE 4'h0

`endif

// [host_glue_pkg.sv]
package host_glue_pkg;

  // one processor bus cycle as seen by the glue
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } cpu_req_t;

  // strobes and register select toward the interface chip
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic [2:0] reg_sel;
  } chip_ctl_t;

  typedef enum logic [1:0] {
    target_none = 2'b00,
    target_chip = 2'b01,
    target_switch = 2'b11
  } target_t;

endpackage

// [sync2.sv]
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser, one per bit
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule // sync2

`default_nettype wire

// [host_glue.sv]
`timescale 1ns/100ps
`default_nettype none
`include "host_glue_defs.svh"

module host_glue (
  input wire logic clock,
  input wire logic nrst,
  input wire host_glue_pkg::cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  output logic cpu_rdata_oe_n,
  output logic cpu_int_n,
  output logic io_space,
  output host_glue_pkg::chip_ctl_t chip_ctl,
  output logic xcvr_en_n,
  output logic xcvr_dir_to_chip,
  output logic [7:0] chip_wdata,
  output logic chip_data_oe_n,
  input wire logic [7:0] chip_rdata,
  input wire logic chip_int_n,
  input wire logic [3:0] addr_switch,
  output logic [7:0] bus_address,
  output host_glue_pkg::target_t target
);

  // reset release and synchronised pins
  logic rst_pipe_ff;
  logic rst_n_ff;
  logic [3:0] switch_s;
  logic int_s;

  // address decode terms
  logic sel;
  logic pick_switch;
  logic win_high;
  logic win_low_clear;
  host_glue_pkg::target_t nxt_target;

  // access direction and destination
  logic rd_req;
  logic wr_req;
  logic chip_hit;
  logic switch_hit;
  logic [7:0] switch_byte;

  // reset released through two flops so the release is clean
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_pipe_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_pipe_ff <= 1'b1;
      rst_n_ff <= rst_pipe_ff;
    end
  end

  // rotary switch pins are asynchronous, so synchronise them
  sync2 #(.WIDTH(4)) switch_sync (
    .clock(clock),
    .rst_n(rst_n_ff),
    .d(addr_switch),
    .q(switch_s)
  );

  // interrupt synchronised inverted: the flops reset to zero,
  // which must mean no interrupt rather than a false one
  sync2 #(.WIDTH(1)) int_sync (
    .clock(clock),
    .rst_n(rst_n_ff),
    .d(~chip_int_n),
    .q(int_s)
  );

  // address decode, combinational from the processor request
  always_comb begin
    // three window bits high, the two above them low
    win_high = &cpu_req.addr[`SEL_HIGH_HI:`SEL_HIGH_LO];
    win_low_clear = ~|cpu_req.addr[`SEL_LOW_HI:`SEL_LOW_LO];
    sel = win_high && win_low_clear;
    pick_switch = cpu_req.addr[`SWITCH_OR_CHIP_SELECT_BIT];
    if (!sel) begin
      nxt_target = host_glue_pkg::target_none;
    end else if (pick_switch) begin
      nxt_target = host_glue_pkg::target_switch;
    end else begin
      nxt_target = host_glue_pkg::target_chip;
    end
  end

  // direction of the access; both strobes up counts as a read
  always_comb begin
    rd_req = sel && cpu_req.rd;
    wr_req = sel && cpu_req.wr && !cpu_req.rd;
  end

  // destination of the access and the byte the switch buffer offers
  always_comb begin
    chip_hit = (nxt_target == host_glue_pkg::target_chip);
    switch_hit = (nxt_target == host_glue_pkg::target_switch);
    switch_byte = {`ADDR_FIXED_NIBBLE, switch_s};
  end

  // io space flag from the top address bit
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      io_space <= 1'b0;
    end else begin
      io_space <= cpu_req.addr[`IO_SPACE_BIT];
    end
  end

  // registered destination, lines up with the strobes it explains
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      target <= host_glue_pkg::target_none;
    end else begin
      target <= nxt_target;
    end
  end

  // chip select, register select and strobes, all registered
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      chip_ctl.cs_n <= 1'b1;
      chip_ctl.rd_n <= 1'b1;
      chip_ctl.wr_n <= 1'b1;
      chip_ctl.reg_sel <= 3'h0;
    end else begin
      chip_ctl.cs_n <= !chip_hit;
      chip_ctl.reg_sel <= cpu_req.addr[`REG_SEL_HI:`REG_SEL_LO];
      // read wins when both are up, so the chip never sees two strobes
      chip_ctl.rd_n <= !rd_req;
      chip_ctl.wr_n <= !wr_req;
    end
  end

  // transceiver enable follows the select, off when unselected
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      xcvr_en_n <= 1'b1;
    end else begin
      xcvr_en_n <= !sel;
    end
  end

  // transceiver direction; only meaningful while enabled
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      xcvr_dir_to_chip <= 1'b0;
    end else begin
      xcvr_dir_to_chip <= cpu_req.wr && !cpu_req.rd;
    end
  end

  // write byte toward the chip, taken every cycle
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      chip_wdata <= 8'h00;
    end else begin
      chip_wdata <= cpu_req.wdata;
    end
  end

  // chip side data driven only for a selected write
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      chip_data_oe_n <= 1'b1;
    end else begin
      chip_data_oe_n <= !wr_req;
    end
  end

  // processor data driven only for a selected read
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cpu_rdata_oe_n <= 1'b1;
    end else begin
      cpu_rdata_oe_n <= !rd_req;
    end
  end

  // read data: switch byte or chip data, zero when nothing is picked
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cpu_rdata <= 8'h00;
    end else begin
      if (switch_hit) begin
        cpu_rdata <= switch_byte;
      end else if (chip_hit) begin
        cpu_rdata <= chip_rdata;
      end else begin
        cpu_rdata <= 8'h00;
      end
    end
  end

  // bus address byte, lags the switch by the synchroniser plus its own register
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bus_address <= 8'h00;
    end else begin
      bus_address <= switch_byte;
    end
  end

  // interrupt level; a missing card floats high, so no interrupt
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cpu_int_n <= 1'b1;
    end else begin
      cpu_int_n <= !int_s;
    end
  end

endmodule // host_glue

`default_nettype wire

// [host_glue_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module host_glue_sva (
  input wire logic clock,
  input wire logic nrst,
  input wire host_glue_pkg::cpu_req_t cpu_req,
  input wire logic cpu_rdata_oe_n,
  input wire logic cpu_int_n,
  input wire host_glue_pkg::chip_ctl_t chip_ctl,
  input wire logic xcvr_en_n,
  input wire logic chip_int_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // top five address bits decide the interface window
  wire logic s = cpu_req.addr[15:11] == 5'h07;
  a_sel_en: assert property (s |=> !xcvr_en_n)
    else $error("no enable");
  a_unsel_quiet: assert property (!s |=> xcvr_en_n && cpu_rdata_oe_n && chip_ctl.wr_n)
    else $error("drives unselected");
  a_switch_read: assert property (s && cpu_req.rd && cpu_req.addr[3] |=> !cpu_rdata_oe_n && chip_ctl.cs_n)
    else $error("switch read");
  a_chip_sel: assert property (s && !cpu_req.addr[3] |=> !chip_ctl.cs_n)
    else $error("chip select");
  a_reg_pass: assert property (s |=> chip_ctl.reg_sel == $past(cpu_req.addr[2:0]))
    else $error("reg select");
  a_read_wins: assert property (s && cpu_req.rd |=> !chip_ctl.rd_n && chip_ctl.wr_n)
    else $error("read strobe");
  a_int_low: assert property ((!chip_int_n)[*3] |=> !cpu_int_n)
    else $error("irq lost");
  a_int_idle: assert property (chip_int_n[*3] |=> cpu_int_n)
    else $error("false irq");
  cover property (s && cpu_req.wr);
  cover property (s && cpu_req.rd && cpu_req.addr[3]);
  cover property (!cpu_int_n);
  cover property (s && cpu_req.rd && !cpu_req.addr[3]);
endmodule // host_glue_sva
bind host_glue host_glue_sva i_sva (
  .clock(clock),
  .nrst(nrst),
  .cpu_req(cpu_req),
  .cpu_rdata_oe_n(cpu_rdata_oe_n),
  .cpu_int_n(cpu_int_n),
  .chip_ctl(chip_ctl),
  .xcvr_en_n(xcvr_en_n),
  .chip_int_n(chip_int_n)
);
`default_nettype wire

// [chip_model.sv]
`timescale 1ns/100ps
`default_nettype none
module chip_model (
  input wire logic clock,
  input wire host_glue_pkg::chip_ctl_t ctl,
  input wire logic [7:0] wd,
  input wire logic irq,
  output logic [7:0] rd,
  output logic int_n
);
  logic [7:0] regs [8];
  logic [7:0] last = 8'h00;
  // register file, written on the write strobe
  always @(posedge clock) begin
    if (!ctl.cs_n && !ctl.wr_n) regs[ctl.reg_sel] <= wd;
    last <= rd;
  end
  // a released bus changes every cycle, never a stale byte
  assign rd = (!ctl.cs_n && !ctl.rd_n) ? regs[ctl.reg_sel] : ~last;
  assign int_n = !irq;
endmodule // chip_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "host_glue_defs.svh"
module testbench;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic irq = 1'b0;
  logic [7:0] crd, rdata, wd, ba;
  logic cint, roe_n, int_n, xen_n, io, dir, doe_n;
  logic [3:0] sw = 4'ha;
  host_glue_pkg::cpu_req_t req = '0;
  host_glue_pkg::chip_ctl_t ctl;
  host_glue_pkg::target_t tg;
  int fails = 0;
  int n_checks = 0;
  host_glue i_dut (.clock(clock), .nrst(nrst), .cpu_req(req), .cpu_rdata(rdata), .cpu_rdata_oe_n(roe_n),
    .cpu_int_n(int_n), .io_space(io), .chip_ctl(ctl), .xcvr_en_n(xen_n), .xcvr_dir_to_chip(dir), .chip_wdata(wd),
    .chip_data_oe_n(doe_n), .chip_rdata(crd), .chip_int_n(cint), .addr_switch(sw), .bus_address(ba), .target(tg));
  chip_model i_chip (.clock(clock), .ctl(ctl), .wd(wd), .irq(irq), .rd(crd), .int_n(cint));
  initial begin
    forever #10 clock = ~clock;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // inputs change 1 ns after an edge; outputs looked at 1 ns after the next
  task automatic go(input logic [15:0] a, input logic r, input logic w, input logic [7:0] d);
    req = {a, r, w, d};
    @(posedge clock);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // new switch value needs two idle cycles to pass the synchroniser
  task automatic t_switch(input logic [3:0] v);
    sw = v;
    repeat (2) go(16'h0000, 1'b0, 1'b0, 8'h00);
    go(16'h3808, 1'b1, 1'b0, 8'h00);
    chk({rdata, roe_n, tg}, {`ADDR_FIXED_NIBBLE, v, 1'b0, host_glue_pkg::target_switch});
    chk(ba, {`ADDR_FIXED_NIBBLE, v});
    chk({ctl[5:3], xen_n}, 4'h6);
  endtask
  task automatic t_chip();
    go(16'h3805, 1'b0, 1'b1, 8'h5a);
    chk({ctl, wd, xen_n}, {6'b100101, 8'h5a, 1'b0});
    chk({dir, doe_n}, 2'b10);
    go(16'h3805, 1'b1, 1'b1, 8'h00);
    go(16'h3805, 1'b1, 1'b1, 8'h00);
    chk({rdata, ctl, tg}, {8'h5a, 6'b010101, host_glue_pkg::target_chip});
    chk({dir, doe_n, roe_n}, 3'b010);
  endtask
  task automatic t_unsel();
    go(16'h7808, 1'b1, 1'b0, 8'h00);
    chk({xen_n, roe_n, ctl[5:3], io}, 6'h3e);
    go(16'h3008, 1'b1, 1'b0, 8'h00);
    chk({xen_n, roe_n, ctl[5:3]}, 5'h1f);
    go(16'h7805, 1'b0, 1'b1, 8'hff);
    chk({xen_n, doe_n, ctl[5:3]}, 5'h1f);
    go(16'hb808, 1'b1, 1'b0, 8'h00);
    chk({xen_n, roe_n, io}, 3'h7);
  endtask
  // reset in mid write: everything quiet at once, then four idle cycles
  task automatic t_reset();
    go(16'h3805, 1'b0, 1'b1, 8'h33);
    nrst = 1'b0;
    go(16'h0000, 1'b0, 1'b0, 8'h00);
    chk({xen_n, roe_n, ctl, doe_n, tg, int_n, rdata, wd},
      {2'b11, 6'b111000, 1'b1, host_glue_pkg::target_none, 1'b1, 16'h0000});
    nrst = 1'b1;
    repeat (4) go(16'h0000, 1'b0, 1'b0, 8'h00);
  endtask
  task automatic t_irq(input logic v);
    irq = v;
    repeat (3) go(16'h0000, 1'b0, 1'b0, 8'h00);
    chk(int_n, !v);
  endtask
  // hang guard, far beyond the few dozen cycles used
  initial begin
    #100us;
    fails++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clock);
    #1 nrst = 1'b1;
    repeat (4) go(16'h0000, 1'b0, 1'b0, 8'h00);
    t_switch(4'ha);
    t_chip();
    t_unsel();
    t_irq(1'b1);
    t_irq(1'b0);
    t_reset();
    t_switch(4'h5);
    test_done();
  end
endmodule // testbench
`default_nettype wire
